// ### rtl/dwl_loader.sv
/*
 * serial word loader: shift register, word clock alignment,
 * forwarding to converter latch or filter fifo, mute, ratio select,
 * AHB-Lite control and status.
 * assumes serial pins are asynchronous and sampled on i_mclk.
 */
`timescale 1ns/1ns
`default_nettype none
module dwl_loader
	import dwl_pkg::*;
#(
	parameter int         POR_CYCLES = DWL_POR_CYCLES,
	parameter logic [7:0] RATIO_MAP  = DWL_MAP_DEFAULT
) (
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic        i_bit_clock,
	input  wire logic        i_serial_data,
	input  wire logic        i_word_clock,
	input  wire logic        i_filter_bypass_n,
	input  wire logic        i_filter_reset_n,
	input  wire logic        i_mute_midscale_n,
	input  wire logic        i_ratio_select_lo,
	input  wire logic        i_ratio_select_hi,
	input  wire logic        i_filter_ready,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic [15:0]      o_dac_code,
	output logic             o_dac_load,
	output logic [15:0]      o_filter_data,
	output logic             o_filter_valid,
	output logic             o_filter_clear,
	output logic [4:0]       o_ratio
);
	if (POR_CYCLES < 1)
	begin : g_por_check
		$error("power-on count must be positive");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [7:0] s1_reg;
	logic [7:0] s2_reg;
	logic       sclk_d_reg;
	logic       wclk_d_reg;
	always_ff @(posedge i_mclk)
	begin
		s1_reg <= {i_bit_clock, i_serial_data, i_word_clock, i_filter_bypass_n,
			i_filter_reset_n, i_mute_midscale_n, i_ratio_select_hi, i_ratio_select_lo};
		s2_reg <= s1_reg;
	end
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			sclk_d_reg <= 1'b0;
			wclk_d_reg <= 1'b0;
		end
		else
		begin
			sclk_d_reg <= s2_reg[7];
			wclk_d_reg <= s2_reg[5];
		end
	end
	logic sclk_rise;
	logic wclk_fall;
	assign sclk_rise = s2_reg[7] && !sclk_d_reg;
	assign wclk_fall = !s2_reg[5] && wclk_d_reg;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [2:0]  ctrl_reg;
	logic        wr_pend_reg;
	logic [3:0]  wr_ofs_reg;
	logic [15:0] latch_reg;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        overrun_reg;
	logic        por_done_reg;
	logic        bypass;
	logic        freset;
	logic        mute;
	assign bypass = !s2_reg[4] || ctrl_reg[DWL_CTRL_BYP];
	assign freset = !s2_reg[3] || ctrl_reg[DWL_CTRL_FRST];
	assign mute   = !s2_reg[2] || ctrl_reg[DWL_CTRL_MUTE];
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;
	// offsets above the map decode to an empty slot: reads zero, writes dropped
	logic       map_hit;
	logic [3:0] bus_ofs;
	assign map_hit = i_haddr[31:4] == 28'h0000000;
	assign bus_ofs = map_hit ? i_haddr[3:0] : 4'hF;
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_ofs_reg  <= 4'h0;
			o_hrdata    <= 32'h00000000;
		end
		else
		begin
			wr_pend_reg <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
			wr_ofs_reg  <= bus_ofs;
			if (i_hsel && i_hready && i_htrans[1] && !i_hwrite)
			begin
				unique case (bus_ofs)
					DWL_OFS_CTRL:   o_hrdata <= {29'h0, ctrl_reg};
					DWL_OFS_STATUS: o_hrdata <= {24'h0, o_ratio, overrun_reg,
						fifo_out_valid, por_done_reg};
					DWL_OFS_LATCH:  o_hrdata <= {16'h0, latch_reg};
					DWL_OFS_FILTER: o_hrdata <= {30'h0, freset, bypass};
					default:        o_hrdata <= 32'h00000000;
				endcase
			end
		end
	end
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			ctrl_reg <= 3'h0;
		else if (wr_pend_reg && wr_ofs_reg == DWL_OFS_CTRL)
			ctrl_reg <= i_hwdata[2:0];
	end

	// ----------------------------------------
	// shift, align, forward
	// ----------------------------------------
	logic [15:0] shift_reg;
	logic [15:0] hold_reg;
	logic [1:0]  edge_cnt_reg;
	logic        fwd;
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			shift_reg <= 16'h0000;
		else if (sclk_rise)
			shift_reg <= {shift_reg[14:0], s2_reg[6]};
	end
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			hold_reg <= 16'h0000;
		else if (wclk_fall)
			hold_reg <= shift_reg;
	end
	// counts rising edges after the word clock fall; second one forwards
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			edge_cnt_reg <= 2'd0;
		else if (wclk_fall)
			edge_cnt_reg <= 2'd2;
		else if (sclk_rise && edge_cnt_reg != 2'd0)
			edge_cnt_reg <= edge_cnt_reg - 2'd1;
	end
	assign fwd = sclk_rise && edge_cnt_reg == 2'd1 && !wclk_fall;

	// ----------------------------------------
	// converter latch and power-on
	// ----------------------------------------
	logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_reg;
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			por_cnt_reg  <= '0;
			por_done_reg <= 1'b0;
		end
		else if (!por_done_reg)
		begin
			por_cnt_reg <= por_cnt_reg + 1'b1;
			if (por_cnt_reg == ($clog2(POR_CYCLES+1))'(POR_CYCLES - 1))
				por_done_reg <= 1'b1;
		end
	end
	// code follows the latch value chosen this cycle, in step with the load pulse
	logic [15:0] latch_next;
	always_comb
	begin
		latch_next = latch_reg;
		if (!por_done_reg)
			latch_next = DWL_MIDSCALE;
		else if (fwd && bypass)
			latch_next = hold_reg;
	end
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			latch_reg  <= DWL_MIDSCALE;
			o_dac_load <= 1'b0;
		end
		else
		begin
			latch_reg  <= latch_next;
			o_dac_load <= por_done_reg && fwd && bypass;
		end
	end
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			o_dac_code <= DWL_MIDSCALE;
		else
			o_dac_code <= mute ? DWL_MIDSCALE : latch_next;
	end

	// ----------------------------------------
	// filter path and ratio
	// ----------------------------------------
	logic push_f;
	assign push_f = fwd && !bypass && !freset && por_done_reg;
	// overflow set wins over a software clear in the same cycle
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			overrun_reg <= 1'b0;
		else if (push_f && !fifo_in_ready)
			overrun_reg <= 1'b1;
		else if (wr_pend_reg && wr_ofs_reg == DWL_OFS_STATUS && i_hwdata[2])
			overrun_reg <= 1'b0;
	end
	dwl_fifo #(
		.WIDTH (DWL_WORD_BITS),
		.DEPTH (DWL_FIFO_DEPTH)
	) u_fifo (
		.i_mclk      (i_mclk),
		.i_resetn    (i_resetn),
		.i_clear     (freset),
		.i_in_data   (hold_reg),
		.i_in_valid  (push_f),
		.o_in_ready  (fifo_in_ready),
		.o_out_data  (o_filter_data),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (i_filter_ready && !freset)
	);
	assign o_filter_valid = fifo_out_valid && !freset;
	assign o_filter_clear = freset;
	logic [1:0] sel;
	assign sel = {s2_reg[1], s2_reg[0]};
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			o_ratio <= 5'd2;
		else
			o_ratio <= 5'd1 << (3'(RATIO_MAP[sel*2 +: 2]) + 3'd1);
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	a_mute_midscale: assert property (mute |=> o_dac_code == DWL_MIDSCALE)
		else $error("mute did not force mid-scale");
	a_load_needs_edges: assert property (o_dac_load |-> $past(fwd) && $past(bypass))
		else $error("latch load without forward edge");
	a_hold_capture: assert property (wclk_fall |=> hold_reg == $past(shift_reg))
		else $error("hold register missed word");
	a_shift_msb: assert property (sclk_rise |=> shift_reg[0] == $past(s2_reg[6]))
		else $error("shift register missed bit");
	a_no_early_load: assert property (wclk_fall |-> !fwd ##1 !fwd)
		else $error("load too early after word clock");
	a_filter_path: assert property (push_f |-> !bypass && edge_cnt_reg == 2'd1)
		else $error("filter push outside forward slot");
	a_filter_reset: assert property (freset |-> !o_filter_valid && o_filter_clear)
		else $error("filter active during reset");
	a_por_midscale: assert property (!por_done_reg |=> latch_reg == DWL_MIDSCALE)
		else $error("latch not mid-scale at power-on");
	a_bypass_route: assert property (fwd && bypass && por_done_reg |=> o_dac_load)
		else $error("bypass word not loaded");
	a_ratio_sel: assert property (##1 $stable(sel)
		|=> o_ratio == 5'd2 << RATIO_MAP[$past(sel)*2 +: 2])
		else $error("ratio mismatch");
	a_late_load: assert property (wclk_fall |=> !o_dac_load [*6])
		else $error("latch loaded too soon after word clock");
	a_load_code: assert property (o_dac_load
		|-> o_dac_code == latch_reg || o_dac_code == DWL_MIDSCALE)
		else $error("load pulse without its code");
	a_latch_hold: assert property (por_done_reg && !(fwd && bypass) |=> $stable(latch_reg))
		else $error("latch changed without a forward");
	a_overrun_sticky: assert property (overrun_reg && !wr_pend_reg |=> overrun_reg)
		else $error("overrun flag lost");
	a_frst_drain: assert property (freset |=> !fifo_out_valid)
		else $error("filter fifo not cleared");
	a_frst_no_push: assert property (freset |-> !push_f)
		else $error("word pushed during filter reset");
	a_ctrl_write: assert property (wr_pend_reg && wr_ofs_reg == DWL_OFS_CTRL
		|=> ctrl_reg == $past(i_hwdata[2:0]))
		else $error("control write lost");
	c_load: cover property (o_dac_load);
	c_filter_push: cover property (push_f);
	c_mute: cover property (mute && por_done_reg);
	c_overrun: cover property (push_f && !fifo_in_ready);
	c_ratio_top: cover property (o_ratio == 5'd16);
endmodule
`default_nettype wire

// ### rtl/dwl_pkg.sv
/*
 * constants of the serial word loader.
 * assumes a 50 MHz system clock and an AHB-Lite register port.
 */
`default_nettype none
package dwl_pkg;
	localparam int          DWL_WORD_BITS   = 16;
	localparam logic [15:0] DWL_MIDSCALE    = 16'h0000;
	localparam logic [15:0] DWL_FULL_POS    = 16'h7FFF;
	localparam logic [15:0] DWL_FULL_NEG    = 16'h8000;
	localparam int          DWL_CLK_MHZ     = 50;
	localparam int          DWL_POR_US      = 30;
	localparam int          DWL_POR_CYCLES  = DWL_POR_US * DWL_CLK_MHZ;
	localparam int          DWL_FIFO_DEPTH  = 16;
	localparam logic [7:0]  DWL_MAP_DEFAULT = 8'hE4;
	localparam logic [3:0]  DWL_OFS_CTRL    = 4'h0;
	localparam logic [3:0]  DWL_OFS_STATUS  = 4'h4;
	localparam logic [3:0]  DWL_OFS_LATCH   = 4'h8;
	localparam logic [3:0]  DWL_OFS_FILTER  = 4'hC;
	localparam int          DWL_CTRL_MUTE   = 0;
	localparam int          DWL_CTRL_BYP    = 1;
	localparam int          DWL_CTRL_FRST   = 2;
endpackage
`default_nettype wire

// ### rtl/dwl_fifo.sv
/*
 * parameterised valid/ready fifo.
 * assumes one clock and synchronous active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module dwl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             i_mclk,
	input  wire logic             i_resetn,
	input  wire logic             i_clear,
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	output logic [WIDTH-1:0]      o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_depth_check
		$error("fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	logic             push;
	logic             pop;
	assign o_in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
	assign o_out_valid = wr_reg != rd_reg;
	assign push = i_in_valid && o_in_ready;
	assign pop  = o_out_valid && i_out_ready;
	assign o_out_data = mem[rd_reg[AW-1:0]];
	always_ff @(posedge i_mclk)
	begin
		if (push)
			mem[wr_reg[AW-1:0]] <= i_in_data;
	end
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn || i_clear)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### verif/dwl_host_model.sv
/* host serial port model: free bit clock, msb-first mono words
   assumes the loader samples data on the bit clock rise */
`timescale 1ns/1ns
`default_nettype none
module dwl_host_model (
	input  wire logic i_mclk,
	output logic      o_bit_clock,
	output logic      o_serial_data,
	output logic      o_word_clock
);
	logic [1:0] div_reg;
	initial
	begin
		div_reg = 2'h0;
		o_bit_clock = 1'b0;
		o_serial_data = 1'b0;
		o_word_clock = 1'b0;
	end
	// bit clock runs free, 8 mclk period
	always @(posedge i_mclk)
	begin
		div_reg <= div_reg + 2'h1;
		if (div_reg == 2'h3)
			o_bit_clock <= ~o_bit_clock;
	end
	task automatic send(input logic [15:0] w, input int pre);
		int i;
		for (i = pre + 15; i >= 0; i--)
		begin
			@(negedge o_bit_clock);
			o_serial_data <= (i > 15) ? ~w[15] : w[i];
			if (i == pre + 15)
				o_word_clock <= 1'b1;
		end
		@(negedge o_bit_clock);
		o_word_clock <= 1'b0;
		o_serial_data <= ~o_serial_data;
	endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/* self-checking bench of the serial word loader
   assumes the host model drives the serial pins */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import dwl_pkg::*;
	logic        mclk, resetn, bclk, sdata, wclk, byp_n, frst_n, mute_n;
	logic        sel_lo, sel_hi, f_ready, hsel, hwrite, hreadyout, hresp;
	logic        dac_load, f_valid, f_clear;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] dac_code, f_data;
	logic [4:0]  ratio;
	int          miscompares, checked, cycles, n, k;
	dwl_host_model dwl_host_model_inst (.i_mclk(mclk), .o_bit_clock(bclk),
		.o_serial_data(sdata), .o_word_clock(wclk));
	dwl_loader #(.POR_CYCLES(10)) dwl_loader_inst (.i_mclk(mclk), .i_resetn(resetn),
		.i_bit_clock(bclk), .i_serial_data(sdata), .i_word_clock(wclk),
		.i_filter_bypass_n(byp_n), .i_filter_reset_n(frst_n), .i_mute_midscale_n(mute_n),
		.i_ratio_select_lo(sel_lo), .i_ratio_select_hi(sel_hi), .i_filter_ready(f_ready),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .o_dac_code(dac_code),
		.o_dac_load(dac_load), .o_filter_data(f_data), .o_filter_valid(f_valid),
		.o_filter_clear(f_clear), .o_ratio(ratio));
	always #10 mclk = ~mclk;
	task automatic close_out;
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			close_out;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wait_load;
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (dac_load !== 1'b1);
	endtask
	task automatic settle;
		repeat (4) @(negedge mclk);
	endtask
	task automatic t_por;
		check(dac_code, 32'h0);
		ahb(1'b0, 32'h4, 32'h0);
		check(rd[0], 1'b1);
	endtask
	task automatic t_bypass;
		byp_n <= 1'b0;
		dwl_host_model_inst.send(16'h8001, 5);
		wait_load;
		check(dac_code, 32'h8001);
		check(n >= 12 && n <= 20, 1'b1);
		dwl_host_model_inst.send(16'h7FFF, 0);
		wait_load;
		check(dac_code, 32'h7FFF);
		ahb(1'b0, 32'h8, 32'h0);
		check(rd, 32'h7FFF);
		check(hresp, 1'b0);
	endtask
	task automatic t_mute;
		mute_n <= 1'b0;
		settle;
		check(dac_code, 32'h0);
		@(posedge mclk);
		mute_n <= 1'b1;
		ahb(1'b1, 32'h0, 32'h1);
		ahb(1'b0, 32'h10, 32'h0);
		check(rd, 32'h0);
		ahb(1'b0, 32'h0, 32'h0);
		check(rd, 32'h1);
		check(dac_code, 32'h0);
		ahb(1'b1, 32'h0, 32'h0);
		settle;
		check(dac_code, 32'h7FFF);
	endtask
	task automatic t_fifo;
		byp_n <= 1'b1;
		for (k = 0; k < 17; k++)
			dwl_host_model_inst.send(16'h1000 + k[15:0], 0);
		repeat (24) @(posedge mclk);
		ahb(1'b0, 32'h4, 32'h0);
		check(rd[2:1], 2'h3);
		check(dac_code, 32'h7FFF);
		f_ready <= 1'b1;
		for (k = 0; k < 16; k++)
		begin
			@(negedge mclk);
			check(f_valid, 1'b1);
			check(f_data, 32'h1000 + k);
		end
		@(negedge mclk);
		check(f_valid, 1'b0);
	endtask
	task automatic t_frst;
		@(posedge mclk);
		f_ready <= 1'b0;
		dwl_host_model_inst.send(16'h0123, 0);
		repeat (24) @(posedge mclk);
		check(f_valid, 1'b1);
		check(f_data, 32'h0123);
		frst_n <= 1'b0;
		settle;
		check(f_clear, 1'b1);
		check(f_valid, 1'b0);
		@(posedge mclk);
		frst_n <= 1'b1;
		settle;
		check(f_clear, 1'b0);
		check(f_valid, 1'b0);
		ahb(1'b1, 32'h0, 32'h6);
		ahb(1'b0, 32'hC, 32'h0);
		check(rd, 32'h3);
		check(f_clear, 1'b1);
		ahb(1'b1, 32'h0, 32'h0);
		ahb(1'b1, 32'h4, 32'h4);
		ahb(1'b0, 32'h4, 32'h0);
		check(rd[2], 1'b0);
	endtask
	task automatic t_ratio;
		for (k = 0; k < 4; k++)
		begin
			@(posedge mclk);
			{sel_hi, sel_lo} <= k[1:0];
			settle;
			check(ratio, 32'h2 << k);
		end
	endtask
	initial
	begin
		{mclk, resetn, byp_n, frst_n, mute_n, sel_lo, sel_hi, f_ready} = 8'h1C;
		{hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
		{miscompares, checked, cycles} = 96'h0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		repeat (14) @(posedge mclk);
		t_por;
		t_bypass;
		t_mute;
		t_fifo;
		t_frst;
		t_ratio;
		close_out;
	end
endmodule
`default_nettype wire
